// ===== core/spimf_pkg.sv
package spimf_pkg;
    // Register addresses on the plain register port
    localparam logic [1:0] ADDR_STATUS = 2'h0;
    localparam logic [1:0] ADDR_CON1 = 2'h1;
    localparam logic [1:0] ADDR_CON2 = 2'h2;
    localparam logic [1:0] ADDR_BUFFER = 2'h3;
    // Status and control fields
    localparam int ST_ENABLE = 15;
    localparam int ST_SIDL = 13;
    localparam int ST_ROV = 6;
    localparam int ST_TBF = 1;
    localparam int ST_RBF = 0;
    // Control one fields
    localparam int C1_CKDIS = 12;
    localparam int C1_DODIS = 11;
    localparam int C1_WIDTH = 10;
    localparam int C1_SMP = 9;
    localparam int C1_CKE = 8;
    localparam int C1_SELECT_PIN_ENABLE = 7;
    localparam int C1_CPOL = 6;
    localparam int C1_MASTER_ENABLE = 5;
    localparam int C1_SECONDARY_PRESCALE_LSB = 2;
    localparam int C1_PRIMARY_PRESCALE_LSB = 0;
    localparam logic [15:0] C1_MASK = 16'h1FFF;
    // Control two fields
    localparam int C2_FRAMING_ENABLE = 15;
    localparam int C2_DIR = 14;
    localparam int C2_POL = 13;
    localparam int C2_DLY = 1;
    localparam logic [15:0] C2_MASK = 16'hE002;
    localparam logic [15:0] REG_RESET = 16'h0000;
    // Edge counts of one transfer
    localparam logic [5:0] EDGES_WORD = 6'h20;
    localparam logic [5:0] EDGES_BYTE = 6'h10;
    localparam logic [5:0] SYNC_PRE = 6'h02;
    localparam logic [5:0] SYNC_LEN = 6'h02;
    typedef enum logic [1:0] {
        SPIMF_IDLE = 2'b00,
        SPIMF_RUN = 2'b01
    } spimf_state_t;
    typedef struct packed {
        logic shift_clock;
        logic shift_clock_en;
        logic data_out;
        logic data_out_en;
        logic select;
        logic select_en;
    } spimf_pins_t;
endpackage : spimf_pkg

// ===== core/spimf_core.sv
// Strobed register access and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
// Contract
// - 16-bit shift register plus software buffer
// - Master drives clock; slave takes it in
// - Enable bit hands pins to port
// - Stop-in-idle halts port during idle
// - Unread data: discard new, set overflow
// - Transmit full set on write, cleared on load
// - Receive full set on move, cleared on read
// - Clock disable releases master clock pin
// - Data-out disable releases data pin
// - Width bit picks 16 or 8 bits
// - Sample phase: end or middle sampling
// - Clock edge bit picks output change edge
// - Polarity bit sets clock idle level
// - Select enable uses slave select in slave
// - Master enable picks master or slave
// - Framed: select pin carries sync, direction bit
// - Sync polarity bit sets pulse level
// - Sync edge bit: coincident or one before
module spimf_core (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Register port
    input wire logic [1:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // Device power state
    input wire logic idle_mode,
    // Serial pins
    input wire logic shift_clock_pin,
    input wire logic serial_data_in_pin,
    input wire logic slave_select_pin_n,
    output spimf_pkg::spimf_pins_t pin_out
);
    logic rst_m_n, rst_q_n;
    logic sck_m, sck_s, sck_p, sdi_m, sdi_s, ss_m, ss_s;
    logic enable_reg, sidl_reg;
    logic [15:0] con1_reg, con2_reg;
    logic [15:0] tx_hold_reg, rx_hold_reg;
    logic tbf_reg, rbf_reg, rov_reg;
    logic [15:0] sr_reg, cap_reg, cap_next;
    logic [5:0] k_reg, kn, ken, pre, last, n2;
    logic act_reg;
    logic [9:0] div_reg, half;
    spimf_pkg::spimf_state_t state_reg;
    logic ckdis, dodis, wide, sample_phase, cke, select_pin_enable, cpol, master;
    logic framing, sync_dir, sync_pol, sync_dly, framed_in;
    logic halt, run_ok, wr_buf, rd_buf, tick, slv_edge, slv_lead;
    logic sync_in_act, selected, abort, start, load, adv, done;
    logic smp_now, shift_now, tog, cke_eff, sync_act;

    function automatic logic [9:0] half_period(input logic [1:0] primary_prescale, input logic [2:0] secondary_prescale);
        logic [9:0] prim;
        logic [3:0] sec;
        prim = 10'h001;
        case (primary_prescale)
            2'h0: prim = 10'h040;
            2'h1: prim = 10'h010;
            2'h2: prim = 10'h004;
            default: prim = 10'h001;
        endcase
        sec = 4'h8 - {1'b0, secondary_prescale};
        half_period = 10'(prim * {6'h00, sec});
    endfunction : half_period

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_m_n <= 1'b0;
            rst_q_n <= 1'b0;
        end else begin
            rst_m_n <= 1'b1;
            rst_q_n <= rst_m_n;
        end
    end

    // Pin synchronisers
    always_ff @(posedge core_clk or negedge rst_q_n) begin
        if (!rst_q_n) begin
            sck_m <= 1'b0;
            sck_s <= 1'b0;
            sck_p <= 1'b0;
            sdi_m <= 1'b0;
            sdi_s <= 1'b0;
            ss_m <= 1'b1;
            ss_s <= 1'b1;
        end else begin
            sck_m <= shift_clock_pin;
            sck_s <= sck_m;
            sck_p <= sck_s;
            sdi_m <= serial_data_in_pin;
            sdi_s <= sdi_m;
            ss_m <= slave_select_pin_n;
            ss_s <= ss_m;
        end
    end

    assign ckdis = con1_reg[spimf_pkg::C1_CKDIS];
    assign dodis = con1_reg[spimf_pkg::C1_DODIS];
    assign wide = con1_reg[spimf_pkg::C1_WIDTH];
    assign sample_phase = con1_reg[spimf_pkg::C1_SMP];
    assign cke = con1_reg[spimf_pkg::C1_CKE];
    assign select_pin_enable = con1_reg[spimf_pkg::C1_SELECT_PIN_ENABLE];
    assign cpol = con1_reg[spimf_pkg::C1_CPOL];
    assign master = con1_reg[spimf_pkg::C1_MASTER_ENABLE];
    assign framing = con2_reg[spimf_pkg::C2_FRAMING_ENABLE];
    assign sync_dir = con2_reg[spimf_pkg::C2_DIR];
    assign sync_pol = con2_reg[spimf_pkg::C2_POL];
    assign sync_dly = con2_reg[spimf_pkg::C2_DLY];
    assign framed_in = framing & sync_dir;
    assign halt = sidl_reg & idle_mode;
    assign run_ok = enable_reg & !halt;
    assign wr_buf = reg_wr && (reg_addr == spimf_pkg::ADDR_BUFFER);
    assign rd_buf = reg_rd && (reg_addr == spimf_pkg::ADDR_BUFFER);

    // Control registers
    always_ff @(posedge core_clk or negedge rst_q_n) begin
        if (!rst_q_n) begin
            enable_reg <= 1'b0;
            sidl_reg <= 1'b0;
            con1_reg <= spimf_pkg::REG_RESET;
            con2_reg <= spimf_pkg::REG_RESET;
        end else if (reg_wr) begin
            if (reg_addr == spimf_pkg::ADDR_STATUS) begin
                enable_reg <= reg_wdata[spimf_pkg::ST_ENABLE];
                sidl_reg <= reg_wdata[spimf_pkg::ST_SIDL];
            end else if (reg_addr == spimf_pkg::ADDR_CON1) begin
                con1_reg <= reg_wdata & spimf_pkg::C1_MASK;
            end else if (reg_addr == spimf_pkg::ADDR_CON2) begin
                con2_reg <= reg_wdata & spimf_pkg::C2_MASK;
            end
        end
    end

    // Read port
    always_ff @(posedge core_clk or negedge rst_q_n) begin
        if (!rst_q_n) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            reg_rdata <= 16'h0000;
            if (reg_addr == spimf_pkg::ADDR_STATUS) begin
                reg_rdata[spimf_pkg::ST_ENABLE] <= enable_reg;
                reg_rdata[spimf_pkg::ST_SIDL] <= sidl_reg;
                reg_rdata[spimf_pkg::ST_ROV] <= rov_reg;
                reg_rdata[spimf_pkg::ST_TBF] <= tbf_reg;
                reg_rdata[spimf_pkg::ST_RBF] <= rbf_reg;
            end else if (reg_addr == spimf_pkg::ADDR_CON1) begin
                reg_rdata <= con1_reg;
            end else if (reg_addr == spimf_pkg::ADDR_CON2) begin
                reg_rdata <= con2_reg;
            end else begin
                reg_rdata <= rx_hold_reg;
            end
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

    // Transmit holding
    always_ff @(posedge core_clk or negedge rst_q_n) begin
        if (!rst_q_n) begin
            tx_hold_reg <= 16'h0000;
            tbf_reg <= 1'b0;
        end else begin
            if (wr_buf) begin
                tx_hold_reg <= reg_wdata;
            end
            // Full on write, empty on load
            if (wr_buf) begin
                tbf_reg <= 1'b1;
            end else if (load) begin
                tbf_reg <= 1'b0;
            end
        end
    end

    // Slave clock edges and frame sync input
    assign slv_edge = sck_s != sck_p;
    assign slv_lead = slv_edge & (sck_s != cpol);
    assign sync_in_act = ss_s == sync_pol;
    assign selected = !select_pin_enable | !ss_s;
    assign abort = !master & !framing & select_pin_enable & ss_s;
    assign start = framed_in ? (master ? (tbf_reg & sync_in_act) : (slv_lead & sync_in_act))
                             : (master ? tbf_reg : selected);
    assign load = (state_reg == spimf_pkg::SPIMF_IDLE) & run_ok & start & tbf_reg;
    assign adv = (state_reg == spimf_pkg::SPIMF_RUN) & run_ok & (master ? tick : slv_edge);

    assign half = half_period(con1_reg[spimf_pkg::C1_PRIMARY_PRESCALE_LSB +: 2], con1_reg[spimf_pkg::C1_SECONDARY_PRESCALE_LSB +: 3]);
    assign tick = master & (div_reg == 10'h000);

    always_ff @(posedge core_clk or negedge rst_q_n) begin
        if (!rst_q_n) begin
            div_reg <= 10'h000;
        end else if (state_reg != spimf_pkg::SPIMF_RUN || !enable_reg) begin
            div_reg <= half - 10'h001;
        end else if (!halt) begin
            if (div_reg == 10'h000) begin
                div_reg <= half - 10'h001;
            end else begin
                div_reg <= div_reg - 10'h001;
            end
        end
    end

    // Edge bookkeeping
    always_comb begin
        cke_eff = cke & !framing;
        n2 = wide ? spimf_pkg::EDGES_WORD : spimf_pkg::EDGES_BYTE;
        // Sync ahead adds one bit clock
        pre = (framing & !sync_dly) ? spimf_pkg::SYNC_PRE : 6'h00;
        // End sampling needs one more half period
        last = pre + n2 + {5'h00, master & sample_phase & !cke_eff};
        kn = k_reg + 6'h01;
        ken = kn - pre;
        // Middle or end of output time
        if (master & sample_phase) begin
            smp_now = cke_eff ? !ken[0] : (ken[0] && ken > 6'h01);
        end else begin
            smp_now = cke_eff ? ken[0] : !ken[0];
        end
        shift_now = cke_eff ? (!ken[0] && ken < n2) : (ken[0] && ken > 6'h01);
        tog = kn <= pre + n2;
        cap_next = cap_reg;
        if (adv && kn > pre && smp_now) begin
            cap_next = {cap_reg[14:0], sdi_s};
        end
    end
    // Move only after the last edge
    assign done = adv & (kn == last);

    // Shift engine
    always_ff @(posedge core_clk or negedge rst_q_n) begin
        if (!rst_q_n) begin
            state_reg <= spimf_pkg::SPIMF_IDLE;
            k_reg <= 6'h00;
            act_reg <= 1'b0;
            sr_reg <= 16'h0000;
            cap_reg <= 16'h0000;
        end else if (!enable_reg) begin
            state_reg <= spimf_pkg::SPIMF_IDLE;
            k_reg <= 6'h00;
            act_reg <= 1'b0;
        end else if (!halt) begin
            case (state_reg)
                spimf_pkg::SPIMF_IDLE: begin
                    act_reg <= 1'b0;
                    if (start) begin
                        state_reg <= spimf_pkg::SPIMF_RUN;
                        k_reg <= (framed_in & !master) ? 6'h01 : 6'h00;
                        cap_reg <= 16'h0000;
                        if (tbf_reg) begin
                            sr_reg <= tx_hold_reg;
                        end
                    end
                end
                spimf_pkg::SPIMF_RUN: begin
                    if (abort) begin
                        state_reg <= spimf_pkg::SPIMF_IDLE;
                    end else if (adv) begin
                        k_reg <= kn;
                        cap_reg <= cap_next;
                        if (kn > pre && shift_now) begin
                            sr_reg <= {sr_reg[14:0], 1'b0};
                        end
                        if (tog) begin
                            act_reg <= ~act_reg;
                        end
                        if (kn == last) begin
                            state_reg <= spimf_pkg::SPIMF_IDLE;
                            act_reg <= 1'b0;
                        end
                    end
                end
                default: state_reg <= spimf_pkg::SPIMF_IDLE;
            endcase
        end
    end

    // Receive holding
    always_ff @(posedge core_clk or negedge rst_q_n) begin
        if (!rst_q_n) begin
            rx_hold_reg <= 16'h0000;
            rbf_reg <= 1'b0;
            rov_reg <= 1'b0;
        end else begin
            // Discard and flag on unread data
            if (done && rbf_reg && !rd_buf) begin
                rov_reg <= 1'b1;
            end else if (reg_wr && reg_addr == spimf_pkg::ADDR_STATUS && !reg_wdata[spimf_pkg::ST_ROV]) begin
                rov_reg <= 1'b0;
            end
            // Full on move, empty on read
            if (done && (!rbf_reg || rd_buf)) begin
                rx_hold_reg <= wide ? cap_next : {8'h00, cap_next[7:0]};
                rbf_reg <= 1'b1;
            end else if (rd_buf) begin
                rbf_reg <= 1'b0;
            end
        end
    end

    // Sync pulse over first or preceding bit clock
    assign sync_act = (state_reg == spimf_pkg::SPIMF_RUN) & (k_reg < spimf_pkg::SYNC_LEN);

    // Pin drive
    always_ff @(posedge core_clk or negedge rst_q_n) begin
        if (!rst_q_n) begin
            pin_out <= '0;
        end else begin
            pin_out.shift_clock <= cpol ^ act_reg;
            pin_out.shift_clock_en <= enable_reg & master & !ckdis;
            pin_out.data_out <= wide ? sr_reg[15] : sr_reg[7];
            pin_out.data_out_en <= enable_reg & !dodis & (master | framing | selected);
            // Sync output only as sync master
            pin_out.select <= sync_pol ? sync_act : !sync_act;
            pin_out.select_en <= enable_reg & framing & !sync_dir;
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_q_n);

    sequence buf_write_s;
        reg_wr && reg_addr == spimf_pkg::ADDR_BUFFER;
    endsequence
    sequence discard_s;
        done && rbf_reg && !rd_buf;
    endsequence
    sequence idle_hold_s;
        (state_reg == spimf_pkg::SPIMF_IDLE && !act_reg) [*2];
    endsequence

    tx_full_set_a: assert property (buf_write_s |=> tbf_reg)
        else $error("transmit full not set after buffer write");
    tx_full_clr_a: assert property (load && !wr_buf |=> !tbf_reg)
        else $error("transmit full not cleared after load");
    rx_full_clr_a: assert property (rd_buf && !done |=> !rbf_reg)
        else $error("receive full not cleared by buffer read");
    overflow_set_a: assert property (discard_s |=> rov_reg && $stable(rx_hold_reg))
        else $error("overflow not flagged or data not discarded");
    pins_off_a: assert property (!enable_reg |=> !pin_out.shift_clock_en && !pin_out.data_out_en
        && !pin_out.select_en)
        else $error("pins driven while port disabled");
    clk_idle_a: assert property (idle_hold_s |=> pin_out.shift_clock == $past(cpol))
        else $error("clock pin not at idle level");
    clk_slave_a: assert property (!master || ckdis |=> !pin_out.shift_clock_en)
        else $error("clock pin driven in slave or disabled");
    dout_dis_a: assert property (dodis |=> !pin_out.data_out_en)
        else $error("data pin driven while disabled");
    halt_freeze_a: assert property (halt && enable_reg |=> $stable(k_reg) && $stable(state_reg))
        else $error("engine moved while halted");
    done_count_a: assert property (done |=> state_reg == spimf_pkg::SPIMF_IDLE && k_reg == $past(last))
        else $error("transfer ended at wrong edge count");
endmodule : spimf_core

// ===== verif/spimf_partner.sv
`timescale 1ns/100ps
module spimf_partner (
    // Wire levels
    input wire logic sck,
    input wire logic dut_data,
    // Driven by the model
    output logic clk_drv,
    output logic data_drv,
    output logic sel_n_drv
);
    logic [15:0] tx_word;
    logic [15:0] rx_word;
    logic cpol;
    logic active;
    logic cke;
    int nbits;
    int skip;
    int lead_n;
    initial begin
        tx_word = 16'h0000;
        rx_word = 16'h0000;
        cpol = 1'b0;
        active = 1'b0;
        cke = 1'b1;
        nbits = 16;
        skip = 0;
        lead_n = 0;
        clk_drv = 1'b0;
        sel_n_drv = 1'b1;
    end
    assign data_drv = tx_word[nbits-1];
    // Edge roles follow the clock-edge setting
    always @(sck) begin
        if (!active && sck === ~cpol) begin
            lead_n++;
            if (cke) begin
                rx_word = {rx_word[14:0], dut_data};
            end else if (skip > 0) begin
                skip--;
            end else begin
                tx_word = tx_word << 1;
            end
        end else if (!active && sck === cpol) begin
            if (cke) begin
                tx_word = tx_word << 1;
            end else begin
                rx_word = {rx_word[14:0], dut_data};
            end
        end
    end
    // Clock only inside a selected frame
    task automatic run_frame(input logic [15:0] word);
        active = 1'b1;
        tx_word = word;
        nbits = 16;
        sel_n_drv = 1'b0;
        #160;
        repeat (16) begin
            clk_drv = ~cpol;
            #80;
            rx_word = {rx_word[14:0], dut_data};
            #80;
            clk_drv = cpol;
            tx_word = tx_word << 1;
            #160;
        end
        sel_n_drv = 1'b1;
        active = 1'b0;
    endtask : run_frame
endmodule : spimf_partner

// ===== verif/spimf_core_tb.sv
`timescale 1ns/100ps
module spimf_core_tb;
    logic core_clk;
    logic rst_n;
    logic [1:0] reg_addr;
    logic [15:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [15:0] reg_rdata;
    logic idle_mode;
    spimf_pkg::spimf_pins_t pin_out;
    logic p_clk;
    logic p_data;
    logic p_sel_n;
    logic sck_w;
    logic sel_n_w;
    logic dout_w;
    logic sync_pol;
    logic [7:0] sync_cnt;
    logic [15:0] s;
    logic [15:0] d;
    logic [15:0] pd;
    int bad_count;
    int compares;

    assign sck_w = pin_out.shift_clock_en ? pin_out.shift_clock : p_clk;
    assign sel_n_w = pin_out.select_en ? pin_out.select : p_sel_n;
    // Released data line has a pull-up
    assign dout_w = pin_out.data_out_en ? pin_out.data_out : 1'b1;

    spimf_core dut (
        .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .idle_mode(idle_mode),
        .shift_clock_pin(sck_w), .serial_data_in_pin(p_data), .slave_select_pin_n(sel_n_w),
        .pin_out(pin_out)
    );
    spimf_partner partner (
        .sck(sck_w), .dut_data(dout_w), .clk_drv(p_clk), .data_drv(p_data), .sel_n_drv(p_sel_n)
    );

    always #20 core_clk = ~core_clk;

    // Sync pulse width, restarted by each buffer write
    always @(posedge core_clk) begin
        if (reg_wr && reg_addr == spimf_pkg::ADDR_BUFFER) begin
            sync_cnt <= 8'h00;
        end else if (pin_out.select_en && pin_out.select === sync_pol) begin
            sync_cnt <= sync_cnt + 8'h01;
        end
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [1:0] a, input logic [15:0] v);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        @(posedge core_clk);
    endtask : wr

    task automatic rd(input logic [1:0] a, output logic [15:0] v);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        v = reg_rdata;
        @(posedge core_clk);
    endtask : rd

    task automatic wait_bit(input int b, output logic [15:0] v);
        v = 16'h0000;
        for (int i = 0; i < 300 && v[b] !== 1'b1; i++) begin
            rd(spimf_pkg::ADDR_STATUS, v);
        end
    endtask : wait_bit

    function automatic logic [15:0] exp_rx(input logic [15:0] w, input logic wide);
        return wide ? w : {8'h00, w[7:0]};
    endfunction : exp_rx

    task automatic master_xfer(input logic wide, input logic cp, input logic ck, input logic sp);
        logic [15:0] v;
        logic [15:0] tx;
        logic [15:0] fx;
        tx = 16'($urandom);
        fx = 16'($urandom);
        wr(spimf_pkg::ADDR_CON1, 16'h0033 | {5'h00, wide, sp, ck, 1'b0, cp, 6'h00});
        wr(spimf_pkg::ADDR_STATUS, 16'hA000);
        repeat (4) @(posedge core_clk);
        check("pins", {13'h0000, pin_out.shift_clock_en, pin_out.shift_clock, pin_out.data_out_en}, {13'h0000, 1'b1, cp, 1'b1});
        partner.cpol = cp;
        partner.cke = ck;
        // First bit stands over the first leading edge
        partner.skip = ck ? 0 : 1;
        partner.lead_n = 0;
        partner.nbits = wide ? 16 : 8;
        partner.tx_word = fx;
        idle_mode <= 1'b1;
        wr(spimf_pkg::ADDR_BUFFER, tx);
        repeat (8) @(posedge core_clk);
        rd(spimf_pkg::ADDR_STATUS, v);
        check("frozen status", v, 16'hA002);
        idle_mode <= 1'b0;
        wait_bit(spimf_pkg::ST_RBF, v);
        check("done status", v, 16'hA001);
        check("sent", exp_rx(partner.rx_word, wide), exp_rx(tx, wide));
        check("bit clocks", 16'(partner.lead_n), wide ? 16'h0010 : 16'h0008);
        rd(spimf_pkg::ADDR_BUFFER, v);
        check("received", v, exp_rx(fx, wide));
        rd(spimf_pkg::ADDR_STATUS, v);
        check("read clears", v, 16'hA000);
    endtask : master_xfer

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_sim

    // About six times the expected run
    initial begin
        #400000;
        bad_count++;
        end_sim();
    end

    initial begin
        core_clk = 1'b0;
        rst_n = 1'b0;
        reg_addr = 2'h0;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        idle_mode = 1'b0;
        sync_pol = 1'b0;
        sync_cnt = 8'h00;
        bad_count = 0;
        compares = 0;
        void'($urandom(50));
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        for (int a = 0; a < 4; a++) begin
            rd(2'(a), s);
            check("reset value", s, spimf_pkg::REG_RESET);
        end
        // Released sync output rests at its inactive high level
        check("pins released", 16'(pin_out), 16'h0002);
        wr(spimf_pkg::ADDR_CON1, 16'hFFFF);
        wr(spimf_pkg::ADDR_CON2, 16'hFFFF);
        rd(spimf_pkg::ADDR_CON1, s);
        check("control one", s, spimf_pkg::C1_MASK);
        rd(spimf_pkg::ADDR_CON2, s);
        check("control two", s, spimf_pkg::C2_MASK);
        wr(spimf_pkg::ADDR_STATUS, 16'hFFFF);
        rd(spimf_pkg::ADDR_STATUS, s);
        check("status", s, 16'hA000);
        check("disabled pins", {13'h0000, pin_out.shift_clock_en, pin_out.data_out_en, pin_out.select_en}, 16'h0000);
        wr(spimf_pkg::ADDR_STATUS, 16'h0000);
        wr(spimf_pkg::ADDR_CON2, 16'h0000);
        for (int i = 0; i < 6; i++) begin
            master_xfer(i < 2 ? i[0] : 1'($urandom), i < 2 ? ~i[0] : 1'($urandom),
                i < 4 ? i[1] : 1'($urandom), i < 4 ? i[0] : 1'($urandom));
        end
        wr(spimf_pkg::ADDR_CON1, 16'h0133);
        wr(spimf_pkg::ADDR_STATUS, 16'h8000);
        repeat (4) @(posedge core_clk);
        partner.cpol = 1'b0;
        partner.cke = 1'b1;
        partner.skip = 0;
        partner.nbits = 8;
        partner.tx_word = 16'h00A5;
        wr(spimf_pkg::ADDR_BUFFER, 16'($urandom));
        wait_bit(spimf_pkg::ST_RBF, s);
        wr(spimf_pkg::ADDR_BUFFER, 16'($urandom));
        wait_bit(spimf_pkg::ST_ROV, s);
        check("overflow", s, 16'h8041);
        rd(spimf_pkg::ADDR_BUFFER, s);
        check("first kept", s, 16'h00A5);
        wr(spimf_pkg::ADDR_STATUS, 16'h8000);
        rd(spimf_pkg::ADDR_STATUS, s);
        check("overflow cleared", s, 16'h8000);
        // Sample phase kept clear as slave
        wr(spimf_pkg::ADDR_CON1, 16'h0580);
        d = 16'($urandom);
        pd = 16'($urandom);
        wr(spimf_pkg::ADDR_BUFFER, d);
        check("slave clock in", {15'h0000, pin_out.shift_clock_en}, 16'h0000);
        #13;
        partner.run_frame(pd);
        @(posedge core_clk);
        wait_bit(spimf_pkg::ST_RBF, s);
        rd(spimf_pkg::ADDR_BUFFER, s);
        check("slave received", s, pd);
        check("slave sent", partner.rx_word, d);
        for (int k = 0; k < 4; k++) begin
            wr(spimf_pkg::ADDR_STATUS, 16'h0000);
            // Clock edge and select enable clear when framed
            wr(spimf_pkg::ADDR_CON1, 16'h0433);
            wr(spimf_pkg::ADDR_CON2, {2'b10, k[1], 11'h000, k[0], 1'b0});
            sync_pol <= k[1];
            wr(spimf_pkg::ADDR_STATUS, 16'h8000);
            d = 16'($urandom);
            pd = 16'($urandom);
            partner.cpol = 1'b0;
            partner.cke = 1'b0;
            // Sync ahead of the word adds one more leading edge
            partner.skip = k[0] ? 1 : 2;
            partner.lead_n = 0;
            partner.nbits = 16;
            partner.tx_word = pd;
            wr(spimf_pkg::ADDR_BUFFER, d);
            wait_bit(spimf_pkg::ST_RBF, s);
            rd(spimf_pkg::ADDR_BUFFER, s);
            check("framed received", s, pd);
            check("framed sent", partner.rx_word, d);
            check("framed clocks", 16'(partner.lead_n), k[0] ? 16'h0010 : 16'h0011);
            check("sync pulse", {8'h00, sync_cnt}, 16'h0008);
        end
        end_sim();
    end
endmodule : spimf_core_tb
